/* ics_defs.svh */
// constants of the inertial calibration and sampling control block
`ifndef ICS_DEFS_SVH
`define ICS_DEFS_SVH
// byte addresses of the registers (lower byte)
`define ICS_A_GX 7'h1A
`define ICS_A_AZ 7'h24
`define ICS_A_DAC 7'h30
`define ICS_A_MSC 7'h34
`define ICS_A_SMPL 7'h36
`define ICS_A_AVG 7'h38
`define ICS_A_SLP 7'h3A
`define ICS_A_CMD 7'h3E
// reset values and field layouts
`define ICS_SMPL_RST 8'h01
`define ICS_RNG_RST 3'b100
`define ICS_TAP_RST 3'h2
`define ICS_RNG_150 3'b010
`define ICS_RNG_75 3'b001
`define ICS_TAP_MIN150 3'h2
`define ICS_TAP_MIN75 3'h4
`define ICS_GOFF_MASK 16'h1FFF
`define ICS_AOFF_MASK 16'h0FFF
`define ICS_CMD_MASK 8'h9F
`define ICS_COMP_BIT 7
`define ICS_C_AN 0
`define ICS_C_FR 1
`define ICS_C_DAC 2
`define ICS_C_NV 3
`define ICS_C_PAN 4
`define ICS_C_SR 7
`define ICS_LP_MIN 8'h0A
// timing: figures in their own unit, cycle counts derived
`define ICS_CLK_NS 8
`define ICS_TB0_NS 610350
`define ICS_TB1_NS 18921000
`define ICS_HS_MS 500
`define ICS_PAN_S 30
`define ICS_TB0_CYC (`ICS_TB0_NS / `ICS_CLK_NS)
`define ICS_TB1_CYC (`ICS_TB1_NS / `ICS_CLK_NS)
`define ICS_HS_CYC (`ICS_HS_MS * 1000000 / `ICS_CLK_NS)
`define ICS_PAN_CYC (`ICS_PAN_S * 64'd1000000000 / `ICS_CLK_NS)
`endif

/* ics_pkg.sv */
// types of the inertial calibration and sampling control block
package ics_pkg;
	typedef enum logic [1:0] {ST_RUN, ST_PAN, ST_SLEEP, ST_ISLEEP} ics_state_e;
	typedef logic signed [17:0] ics_samp_t;
	typedef struct packed {
		ics_state_e st;
		logic [5:0][15:0] off;
		logic [5:0][15:0] nv_off;
		logic [7:0] smpl;
		logic [7:0] nv_smpl;
		logic [2:0] rng;
		logic [2:0] nv_rng;
		logic [2:0] tap;
		logic [2:0] nv_tap;
		logic comp;
		logic nv_comp;
		logic [11:0] dac_reg;
		logic [11:0] dac_out;
		logic [7:0] cmd;
		logic [31:0] tb_cnt;
		logic [6:0] ns_cnt;
		logic [31:0] lcnt;
		logic [7:0] slp_left;
		logic [2:0][17:0] pan_avg;
		logic [15:0] rd_word;
		logic [2:0] burst;
		logic [2:0] sy_cs;
		logic [2:0] sy_tg;
		logic tick;
		logic t2;
		logic t3;
		logic clr;
		logic dv;
		logic lowp;
		logic slp;
		logic [5:0][13:0] dout;
	} ics_core_s;
	typedef struct packed {
		logic [15:0] rx;
		logic [3:0] cnt;
	} ics_lrx_s;
	typedef struct packed {
		logic [15:0] tx;
		logic [15:0] word;
		logic tg;
		logic dout;
	} ics_ltx_s;
	typedef struct packed {
		logic [127:0][17:0] hist;
		logic signed [24:0] sum;
		logic [6:0] wp;
		logic [2:0] m;
		logic [17:0] y;
	} ics_avg_s;
endpackage

/* ics_top.sv */
// calibration, command, sampling, sleep and filter control of the inertial block
`include "ics_defs.svh"

// one averaging stage of 2^m taps, a running sum over a sample history
module ics_avg (
	input wire logic clk,
	input wire logic rst,
	input wire logic clr,
	input wire logic en,
	input wire logic [2:0] m,
	input wire ics_pkg::ics_samp_t x,
	output ics_pkg::ics_samp_t y
);
	import ics_pkg::*;
	ics_avg_s s; // stage state
	ics_avg_s n; // next stage state
	logic [6:0] old_ix; // slot of the sample leaving the window

	assign y = ics_samp_t'(s.y);
	assign old_ix = s.wp - (7'h01 << m);

	// a tap change restarts the window, a stale sum would never recover
	always_comb begin
		n = s;
		if (clr || m != s.m) begin
			n = '0;
			n.m = m;
		end else if (en) begin
			n.sum = s.sum + 25'(x) - 25'(signed'(s.hist[old_ix]));
			n.hist[s.wp] = x;
			n.wp = s.wp + 7'h01;
			n.y = 18'(n.sum >>> m);
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end
endmodule

// register bank, command engine, sample timer and serial link
module ics_top #(
	parameter logic [31:0] TB0_CYC = 32'(`ICS_TB0_CYC),
	parameter logic [31:0] TB1_CYC = 32'(`ICS_TB1_CYC),
	parameter logic [31:0] HS_CYC = 32'(`ICS_HS_CYC),
	parameter logic [31:0] PAN_CYC = 32'(`ICS_PAN_CYC),
	parameter int COMP_SH = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	output logic dout,
	input wire logic [13:0] raw_gx,
	input wire logic [13:0] raw_gy,
	input wire logic [13:0] raw_gz,
	input wire logic [13:0] raw_ax,
	input wire logic [13:0] raw_ay,
	input wire logic [13:0] raw_az,
	output logic [13:0] gyro_x_output,
	output logic [13:0] gyro_y_output,
	output logic [13:0] gyro_z_output,
	output logic [13:0] accel_x_output,
	output logic [13:0] accel_y_output,
	output logic [13:0] accel_z_output,
	output logic data_valid,
	output logic low_power,
	output logic asleep,
	output logic [11:0] dac_value
);
	import ics_pkg::*;
	ics_core_s c; // core state, clk domain
	ics_core_s n; // next core state
	ics_lrx_s lr; // link receive state, cleared by deselect
	ics_lrx_s lrn;
	ics_ltx_s lt; // link transmit state, survives deselect
	ics_ltx_s ltn;
	logic lk_rst; // link counter reset
	logic [5:0][13:0] raw; // raw sensor samples
	ics_samp_t [5:0] xin; // corrected samples into the filter
	ics_samp_t [5:0] s1; // first stage outputs
	ics_samp_t [5:0] fy; // second stage outputs
	logic got; // a received word has crossed over
	logic cs_fall; // select went low
	logic [15:0] wd; // received word, held stable by the link
	logic [7:0] bd; // written byte
	logic [15:0] rv; // value of the addressed register
	logic [1:0] gsh; // gyro output shift for the range

	assign raw = {raw_az, raw_ay, raw_ax, raw_gz, raw_gy, raw_gx};
	assign gyro_x_output = c.dout[0];
	assign gyro_y_output = c.dout[1];
	assign gyro_z_output = c.dout[2];
	assign accel_x_output = c.dout[3];
	assign accel_y_output = c.dout[4];
	assign accel_z_output = c.dout[5];
	assign data_valid = c.dv;
	assign low_power = c.lowp;
	assign asleep = c.slp;
	assign dac_value = c.dac_out;
	assign dout = lt.dout;
	assign lk_rst = rst | cs_n;

	// per-axis offset add and two cascaded stages
	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_ch
			if (g < 3) begin : g_gy
				// gyro runs at a quarter LSB so the fine offset adds exactly
				assign xin[g] = ics_samp_t'(signed'({raw[g], 2'b00}))
					+ ics_samp_t'(signed'(c.off[g][12:0]))
					- (c.comp ? ics_samp_t'(signed'(raw[g + 3])) >>> COMP_SH : '0);
			end else begin : g_ac
				assign xin[g] = ics_samp_t'(signed'(raw[g]))
					+ ics_samp_t'(signed'(c.off[g][11:0]));
			end
			ics_avg u_s1 (
				.clk(clk),
				.rst(rst),
				.clr(c.clr),
				.en(c.tick && c.st == ST_RUN),
				.m(c.tap),
				.x(xin[g]),
				.y(s1[g])
			);
			ics_avg u_s2 (
				.clk(clk),
				.rst(rst),
				.clr(c.clr),
				.en(c.t2),
				.m(c.tap),
				.x(s1[g]),
				.y(fy[g])
			);
		end
	endgenerate

	assign got = c.sy_tg[2] ^ c.sy_tg[1];
	assign cs_fall = c.sy_cs[2] & ~c.sy_cs[1];
	assign wd = lt.word;
	assign bd = wd[7:0];
	assign gsh = (c.rng == `ICS_RNG_75) ? 2'd0 : (c.rng == `ICS_RNG_150) ? 2'd1 : 2'd2;

	// readback mux; write-only registers read as zero
	always_comb begin
		rv = 16'h0000;
		for (int i = 0; i < 6; i++) begin
			if (wd[14:9] == 6'((`ICS_A_GX >> 1) + i)) begin
				rv = c.off[i];
			end
		end
		case ({wd[14:9], 1'b0})
			`ICS_A_DAC: rv = {4'h0, c.dac_reg};
			`ICS_A_MSC: rv = {8'h00, c.comp, 7'h00};
			`ICS_A_SMPL: rv = {8'h00, c.smpl};
			`ICS_A_AVG: rv = {5'h00, c.rng, 5'h00, c.tap};
			default: rv = rv;
		endcase
	end

	// core next state
	always_comb begin
		n = c;
		n.sy_cs = {c.sy_cs[1:0], cs_n};
		n.sy_tg = {c.sy_tg[1:0], lt.tg};
		n.tick = 1'b0;
		n.clr = 1'b0;
		n.dv = 1'b0;
		n.t2 = c.tick && (c.st == ST_RUN);
		n.t3 = c.t2;
		// sample timer, stopped while asleep
		if (c.st == ST_RUN || c.st == ST_PAN) begin
			if (c.tb_cnt >= (c.smpl[7] ? TB1_CYC : TB0_CYC) - 32'h1) begin
				n.tb_cnt = '0;
				if (c.ns_cnt >= c.smpl[6:0]) begin
					n.ns_cnt = '0;
					n.tick = 1'b1;
				end else begin
					n.ns_cnt = c.ns_cnt + 7'h01;
				end
			end else begin
				n.tb_cnt = c.tb_cnt + 32'h1;
			end
		end
		// publish filtered data, gyro axes scaled to the range
		if (c.t3) begin
			n.dv = 1'b1;
			for (int i = 0; i < 6; i++) begin
				n.dout[i] = (i < 3) ? 14'(fy[i] >>> gsh) : 14'(fy[i]);
			end
		end
		case (c.st)
			ST_RUN: begin
				// one command per cycle, reset first
				if (c.cmd[`ICS_C_SR]) begin
					n.off = c.nv_off;
					n.smpl = c.nv_smpl;
					n.rng = c.nv_rng;
					n.tap = c.nv_tap;
					n.comp = c.nv_comp;
					n.cmd = 8'h00;
					n.burst = 3'h0;
					n.tb_cnt = '0;
					n.ns_cnt = '0;
					n.clr = 1'b1;
					n.dout = '0;
				end else if (c.cmd[`ICS_C_FR]) begin
					n.off = '0;
					n.nv_off = '0;
					n.clr = 1'b1;
					n.dout = '0;
					n.cmd[`ICS_C_FR] = 1'b0;
				end else if (c.cmd[`ICS_C_AN]) begin
					for (int i = 0; i < 3; i++) begin
						n.off[i] = 16'(c.off[i] - 16'(fy[i])) & `ICS_GOFF_MASK;
						n.nv_off[i] = n.off[i];
					end
					n.clr = 1'b1;
					n.dout = '0;
					n.cmd[`ICS_C_AN] = 1'b0;
				end else if (c.cmd[`ICS_C_PAN]) begin
					n.st = ST_PAN;
					n.lcnt = '0;
					n.pan_avg = '0;
				end else if (c.cmd[`ICS_C_NV]) begin
					n.nv_off = c.off;
					n.nv_smpl = c.smpl;
					n.nv_rng = c.rng;
					n.nv_tap = c.tap;
					n.nv_comp = c.comp;
					n.cmd[`ICS_C_NV] = 1'b0;
				end else if (c.cmd[`ICS_C_DAC]) begin
					n.dac_out = c.dac_reg;
					n.cmd[`ICS_C_DAC] = 1'b0;
				end
			end
			ST_PAN: begin
				// offline: slow average of bare gyro samples, no data out after the first three cycles, where a tick from run can still publish
				n.lcnt = c.lcnt + 32'h1;
				if (c.tick) begin
					for (int i = 0; i < 3; i++) begin
						n.pan_avg[i] = 18'(signed'(c.pan_avg[i])
							+ ((ics_samp_t'(signed'({raw[i], 2'b00}))
							- signed'(c.pan_avg[i])) >>> 6));
					end
				end
				if (c.lcnt >= PAN_CYC - 32'h1) begin
					for (int i = 0; i < 3; i++) begin
						n.off[i] = 16'(-signed'(c.pan_avg[i])) & `ICS_GOFF_MASK;
						n.nv_off[i] = n.off[i];
					end
					n.clr = 1'b1;
					n.dout = '0;
					n.cmd[`ICS_C_PAN] = 1'b0;
					n.st = ST_RUN;
				end
			end
			ST_SLEEP: begin
				// half-second steps down to zero
				if (c.lcnt >= HS_CYC - 32'h1) begin
					n.lcnt = '0;
					n.slp_left = c.slp_left - 8'h01;
					if (c.slp_left <= 8'h01) begin
						n.st = ST_RUN;
					end
				end else begin
					n.lcnt = c.lcnt + 32'h1;
				end
			end
			ST_ISLEEP: begin
				if (cs_fall) begin
					n.st = ST_RUN;
				end
			end
			default: n.st = ST_RUN;
		endcase
		// received frames: burst words, writes, reads
		if (got) begin
			if (c.burst != 3'h0) begin
				n.rd_word = {2'b00, c.dout[c.burst]};
				n.burst = (c.burst == 3'h5) ? 3'h0 : c.burst + 3'h1;
			end else if (wd[15]) begin
				for (int i = 0; i < 6; i++) begin
					if (wd[14:9] == 6'((`ICS_A_GX >> 1) + i)) begin
						n.off[i] = (wd[8] ? {bd, c.off[i][7:0]} : {c.off[i][15:8], bd})
							& ((i < 3) ? `ICS_GOFF_MASK : `ICS_AOFF_MASK);
					end
				end
				case (wd[14:8])
					`ICS_A_DAC: n.dac_reg[7:0] = bd;
					`ICS_A_DAC + 7'h01: n.dac_reg[11:8] = bd[3:0];
					`ICS_A_MSC: n.comp = bd[`ICS_COMP_BIT];
					`ICS_A_SMPL: n.smpl = bd;
					`ICS_A_AVG + 7'h01: begin
						// unknown range codes are ignored
						if (bd[2:0] == `ICS_RNG_RST || bd[2:0] == `ICS_RNG_150
							|| bd[2:0] == `ICS_RNG_75) begin
							n.rng = bd[2:0];
						end
					end
					`ICS_A_AVG: n.tap = bd[2:0];
					`ICS_A_SLP: begin
						if (bd != 8'h00) begin
							n.slp_left = bd;
							n.lcnt = '0;
							n.st = ST_SLEEP;
						end
					end
					`ICS_A_SLP + 7'h01: begin
						if (bd[0]) begin
							n.st = ST_ISLEEP;
						end
					end
					`ICS_A_CMD: n.cmd = c.cmd | (bd & `ICS_CMD_MASK);
					default: n.cmd = n.cmd;
				endcase
			end else if (wd[14:9] == 6'(`ICS_A_CMD >> 1)) begin
				n.rd_word = {2'b00, c.dout[0]};
				n.burst = 3'h1;
			end else begin
				n.rd_word = rv;
			end
		end
		// a range change may lift the taps
		// clamp inside the process, an outside decode of n would loop back
		if (n.rng == `ICS_RNG_75 && n.tap < `ICS_TAP_MIN75) begin
			n.tap = `ICS_TAP_MIN75;
		end else if (n.rng == `ICS_RNG_150 && n.tap < `ICS_TAP_MIN150) begin
			n.tap = `ICS_TAP_MIN150;
		end
		n.lowp = n.smpl >= `ICS_LP_MIN;
		// registered so the pin comes straight from a flip-flop
		n.slp = (n.st == ST_SLEEP) || (n.st == ST_ISLEEP);
	end

	// core register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			c <= '0;
			c.st <= ST_RUN;
			c.smpl <= `ICS_SMPL_RST;
			c.nv_smpl <= `ICS_SMPL_RST;
			c.rng <= `ICS_RNG_RST;
			c.nv_rng <= `ICS_RNG_RST;
			c.tap <= `ICS_TAP_RST;
			c.nv_tap <= `ICS_TAP_RST;
			c.sy_cs <= 3'h7;
		end else begin
			c <= n;
		end
	end

	// link: shift in on sclk rise, reply drives out one bit per rise
	always_comb begin
		lrn = lr;
		lrn.rx = {lr.rx[14:0], din};
		lrn.cnt = lr.cnt + 4'h1;
		ltn = lt;
		if (lr.cnt == 4'hF) begin
			// rd_word is quiet here: it only moves just after a word lands
			ltn.word = {lr.rx[14:0], din};
			ltn.tg = ~lt.tg;
			ltn.tx = c.rd_word;
			ltn.dout = c.rd_word[15];
		end else begin
			ltn.tx = {lt.tx[14:0], 1'b0};
			ltn.dout = lt.tx[14];
		end
	end

	// bit counter restarts whenever select is high
	always_ff @(posedge sclk or posedge lk_rst) begin
		if (lk_rst) begin
			lr <= '0;
		end else begin
			lr <= lrn;
		end
	end

	// word and toggle hold across frames
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			lt <= '0;
		end else begin
			lt <= ltn;
		end
	end

	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence pan_go;
		c.st == ST_RUN && c.cmd[`ICS_C_PAN] && c.cmd[1:0] == 2'b00 && !c.cmd[`ICS_C_SR];
	endsequence
	sequence offline;
		c.st == ST_PAN && !c.dv;
	endsequence

	AST_PAN_OFFLINE: assert property (pan_go |=> offline [*4])
		else $error("precision autonull did not go offline");
	AST_FR_ZERO: assert property (c.st == ST_RUN && c.cmd[1:0] == 2'b10
		&& !c.cmd[`ICS_C_SR] && !got |=> c.off == '0 && c.nv_off == '0 && c.dout == '0)
		else $error("factory restore left offsets or data");
	AST_CMD_CLEAR: assert property ($rose(c.cmd[`ICS_C_DAC]) |-> ##[1:8] !c.cmd[`ICS_C_DAC])
		else $error("dac latch bit not cleared");
	AST_DAC_LATCH: assert property ($fell(c.cmd[`ICS_C_DAC]) && !$past(c.cmd[`ICS_C_SR])
		|-> c.dac_out == $past(c.dac_reg))
		else $error("dac value not latched");
	AST_SR_RELOAD: assert property (c.st == ST_RUN && c.cmd[`ICS_C_SR] && !got
		|=> c.smpl == $past(c.nv_smpl) && c.tap >= $past(c.nv_tap) && c.cmd == 8'h00)
		else $error("software reset did not reload controls");
	AST_WAKE: assert property (c.st == ST_ISLEEP && cs_fall && !got |=> c.st == ST_RUN)
		else $error("select fall did not wake");
	AST_TAPMIN: assert property ((c.rng == `ICS_RNG_75 |-> c.tap >= `ICS_TAP_MIN75)
		and (c.rng == `ICS_RNG_150 |-> c.tap >= `ICS_TAP_MIN150))
		else $error("tap exponent below range minimum");
	AST_LOWPOW: assert property ($changed(c.smpl) |=> low_power == (c.smpl >= `ICS_LP_MIN))
		else $error("low power flag wrong");
	AST_OFFMASK: assert property (c.off[0][15:13] == 3'h0 && c.off[3][15:12] == 4'h0)
		else $error("unused offset bits set");
	AST_NOTICK_SLEEP: assert property (asleep |=> !c.tick)
		else $error("sampling while asleep");
endmodule

/* ics_host.sv */
// host-side serial master model that drives the link of the control block
module ics_host (
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout
);
	timeunit 1ns;
	timeprecision 100ps;
	// link clock idles high and stands still between frames
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b0;
	end
	// one 16-bit frame, msb first; r collects what the device shifted out
	// the gap comes first so a caller sees the frame's effect promptly
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		#(1us);
		cs_n = 1'b0;
		// odd lead time keeps link edges off core clock edges, except that back-to-back frames drift and every fourth lands on them
		#(83ns);
		for (int i = 15; i >= 0; i--) begin
			sclk = 1'b0;
			din = w[i];
			#(80ns);
			// sample just before the rise, while the reply bit stands
			r[i] = dout;
			sclk = 1'b1;
			#(80ns);
		end
		cs_n = 1'b1;
		// released line shows the inverse, never a stale copy
		din = ~din;
	endtask
endmodule

/* inertial_cal_and_sampling_ctrl_tb.sv */
// self-checking bench of the calibration and sampling control block
module inertial_cal_and_sampling_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst, sclk, cs_n, din, dout, data_valid, low_power, asleep;
	logic [13:0] raw_gx, raw_gy, raw_gz, raw_ax, raw_ay, raw_az;
	logic [13:0] gxo, gyo, gzo, axo, ayo, azo;
	logic [11:0] dac_value;
	logic [15:0] v; // scratch reply word
	int fails, n_checks, n;
	// short counts keep the run small; expectations follow from these
	ics_top #(.TB0_CYC(32'd4), .TB1_CYC(32'd8), .HS_CYC(32'd64), .PAN_CYC(32'd64), .COMP_SH(4))
	dut_u (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
		.raw_gx(raw_gx), .raw_gy(raw_gy), .raw_gz(raw_gz),
		.raw_ax(raw_ax), .raw_ay(raw_ay), .raw_az(raw_az),
		.gyro_x_output(gxo), .gyro_y_output(gyo), .gyro_z_output(gzo),
		.accel_x_output(axo), .accel_y_output(ayo), .accel_z_output(azo),
		.data_valid(data_valid), .low_power(low_power), .asleep(asleep),
		.dac_value(dac_value));
	ics_host host_u (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
	// core clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// register write frame, then let the core take it
	task automatic wr(input logic [15:0] w);
		host_u.xfer(w, v);
		repeat (6) @(negedge clk);
	endtask
	// read: the reply is loaded at the end of the next frame, shifted in the one after
	task automatic rc(input logic [6:0] a, input logic [15:0] e);
		host_u.xfer({1'b0, a, 8'h00}, v);
		host_u.xfer(16'h0000, v);
		host_u.xfer(16'h0000, v);
		chk(v, e);
	endtask
	// cycles between two output-valid pulses, bounded
	task automatic gap(output int g);
		int k;
		k = 0;
		while (data_valid !== 1'b1 && k < 400) begin
			@(negedge clk);
			k++;
		end
		g = 0;
		do begin
			@(negedge clk);
			g++;
		end while (data_valid !== 1'b1 && g < 400);
	endtask
	task automatic set_raw(input logic [13:0] gx, input logic [13:0] gy, input logic [13:0] ax);
		@(negedge clk);
		raw_gx = gx;
		raw_gy = gy;
		raw_ax = ax;
		repeat (400) @(negedge clk);
	endtask
	task automatic t_reset;
		chk(16'(low_power), 16'h0000);
		chk(16'(dac_value), 16'h0000);
		rc(7'h36, 16'h0001);
		rc(7'h38, 16'h0402);
		rc(7'h1C, 16'h0000);
		rc(7'h3A, 16'h0000);
		$display("test reset done");
	endtask
	// offsets with unused upper bits, then their effect on outputs
	task automatic t_offsets;
		wr(16'h9B1F);
		wr(16'h9AD8);
		rc(7'h1A, 16'h1FD8);
		wr(16'h9BFF);
		rc(7'h1A, 16'h1FD8);
		wr(16'hA1FF);
		wr(16'hA0FB);
		rc(7'h20, 16'h0FFB);
		set_raw(14'h0000, 14'h0000, 14'h0000);
		chk(16'(gxo), 16'h3FF6);
		chk(16'(axo), 16'h3FFB);
		chk(16'(gyo), 16'h0000);
		$display("test offsets done");
	endtask
	// outputs must drop at once, before the filter could have decayed
	task automatic t_factory;
		wr(16'hBE02);
		chk(16'(gxo), 16'h0000);
		rc(7'h1A, 16'h0000);
		rc(7'h20, 16'h0000);
		$display("test factory done");
	endtask
	task automatic t_rate;
		gap(n);
		gap(n);
		chk(16'(n), 16'd8);
		wr(16'hB60A);
		chk(16'(low_power), 16'h0001);
		wr(16'hB609);
		chk(16'(low_power), 16'h0000);
		gap(n);
		gap(n);
		chk(16'(n), 16'd40);
		wr(16'hB683);
		gap(n);
		gap(n);
		chk(16'(n), 16'd32);
		chk(16'(low_power), 16'h0001);
		wr(16'hB601);
		$display("test rate done");
	endtask
	// range goes first, taps after it
	task automatic t_range;
		wr(16'hB902);
		rc(7'h38, 16'h0202);
		wr(16'hB901);
		rc(7'h38, 16'h0104);
		wr(16'hB801);
		rc(7'h38, 16'h0104);
		wr(16'hB903);
		rc(7'h38, 16'h0104);
		wr(16'hB904);
		wr(16'hB802);
		rc(7'h38, 16'h0402);
		$display("test range done");
	endtask
	// burst of the settled outputs, then autonull of two gyro biases
	task automatic t_autonull;
		logic [15:0] e [6];
		e = '{16'h0014, 16'h3FF8, 16'h0000, 16'h0005, 16'h0000, 16'h0000};
		set_raw(14'h0014, 14'h3FF8, 14'h0005);
		host_u.xfer(16'h3E00, v);
		// first frame after the start still carries the older reply
		for (int i = 0; i < 7; i++) begin
			host_u.xfer(16'h0000, v);
			if (i > 0) begin
				chk(v, e[i - 1]);
			end
		end
		wr(16'hBE01);
		chk(16'(gxo), 16'h0000);
		rc(7'h1A, 16'h1FB0);
		rc(7'h1C, 16'h0020);
		rc(7'h1E, 16'h0000);
		repeat (400) @(negedge clk);
		chk(16'(gxo), 16'h0000);
		$display("test autonull done");
	endtask
	// precision autonull on still gyros, then acceleration compensation
	task automatic t_pan;
		set_raw(14'h0000, 14'h0000, 14'h0000);
		wr(16'hBE10);
		repeat (100) @(negedge clk);
		rc(7'h1A, 16'h0000);
		rc(7'h1C, 16'h0000);
		wr(16'hB480);
		rc(7'h34, 16'h0080);
		set_raw(14'h0000, 14'h0000, 14'h0040);
		chk(16'(gxo), 16'h3FFF);
		wr(16'hB400);
		$display("test pan done");
	endtask
	// both bytes loaded, output moves only on the latch command
	task automatic t_dac;
		wr(16'hB0D9);
		wr(16'hB104);
		chk(16'(dac_value), 16'h0000);
		wr(16'hBE04);
		chk(16'(dac_value), 16'h04D9);
		$display("test dac done");
	endtask
	// saved period survives a software reset, unsaved one does not
	task automatic t_nvsave;
		wr(16'hB605);
		wr(16'hBE08);
		wr(16'hB603);
		wr(16'hBE80);
		repeat (20) @(negedge clk);
		rc(7'h36, 16'h0005);
		wr(16'hB601);
		$display("test nvsave done");
	endtask
	task automatic t_sleep;
		int c;
		c = 0;
		fork
			wr(16'hBA02);
		join_none
		// the forked frame alone takes about 460 clocks
		repeat (800) begin
			@(negedge clk);
			if (asleep === 1'b1) c++;
		end
		chk(16'(c >= 127 && c <= 129), 16'h0001);
		wr(16'hBB01);
		repeat (200) @(negedge clk);
		chk(16'(asleep), 16'h0001);
		wr(16'h0000);
		chk(16'(asleep), 16'h0000);
		$display("test sleep done");
	endtask
	// closing task: counts, verdict, end of run
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// watchdog well beyond the expected span of the tests
	initial begin
		#(900us);
		fails++;
		results();
	end
	// main sequence
	initial begin
		fails = 0;
		n_checks = 0;
		rst = 1'b1;
		{raw_gx, raw_gy, raw_gz, raw_ax, raw_ay, raw_az} = '0;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (8) @(negedge clk);
		t_reset();
		t_offsets();
		t_factory();
		t_rate();
		t_range();
		t_autonull();
		t_pan();
		t_dac();
		t_nvsave();
		t_sleep();
		results();
	end
endmodule
